// ==== dea_top.sv ====
// Added by the designer: the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module dea_top
  import dea_pkg::*;
#(
  parameter bit LARGE_ARRAY  = 1'b1,              // 256-byte variant when set
  parameter int PWRT_CYCLES  = PWRT_CYCLES_DEF,   // power-up hold length
  parameter int WRITE_CYCLES = WRITE_CYCLES_DEF   // erase plus program length
)
(
  // clock and reset
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                ce,
  // apb slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [PADDR_W-1:0]  paddr,
  input  wire logic [31:0]         pwdata,
  output var  logic [31:0]         prdata,
  output var  logic                pready,
  output var  logic                pslverr,
  // reset sources and power-up strap, asynchronous pins
  input  wire logic                external_reset_pin_n,
  input  wire logic                watchdog_timeout,
  input  wire logic                brownout_reset,
  input  wire logic                pwrt_enable,
  // completion flag mirror
  output var  logic                program_done_flag
);

  localparam int PHASE_CYCLES = (WRITE_CYCLES + 1) / 2;  // erase and program halves

  // synchronisers, stage one read only by stage two
  logic [3:0]  pin_meta_reg;
  logic [3:0]  pin_sync_reg;
  // apb datapath
  logic [31:0] prdata_reg;
  logic        pready_reg;
  logic        pslverr_reg;
  // register state
  logic [7:0]  buffer_reg;      // nv_byte_buffer
  logic [7:0]  loc_reg;         // nv_location_select
  logic        rd_reg;
  logic        wr_reg;
  logic        enable_reg;
  logic        abort_reg;
  logic        done_reg;
  // engine state
  dea_wcycle_t wc_state;
  logic [31:0] wc_cnt_reg;
  logic [7:0]  wc_addr_reg;     // latched so software edits do not disturb a write
  logic [7:0]  wc_data_reg;
  logic [31:0] pwrt_cnt_reg;
  logic        pwrt_done_reg;
  // combinational
  logic        setup_ph;
  logic        wr_ev;
  logic        mapped;
  logic        any_rst;
  logic        pwrt_hold;
  logic        armed;
  logic        start_rd;
  logic        start_wr;
  logic        phase_end;
  logic        abort_ev;
  logic        prog_end;
  logic        mem_we;
  logic [7:0]  mem_wdata;
  logic [7:0]  mem_rdata;
  logic [7:0]  loc_eff;
  logic [31:0] rd_mux;

  // bring the pins into pclk; the reset pin is active low
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_meta_reg <= 4'h0;
      pin_sync_reg <= 4'h0;
    end
    else if (ce)
    begin
      pin_meta_reg <= {pwrt_enable, brownout_reset, watchdog_timeout, ~external_reset_pin_n};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  assign any_rst = |pin_sync_reg[2:0];

  // apb decode
  assign setup_ph = psel && !penable;
  assign wr_ev    = psel && penable && pready_reg && pwrite;
  assign mapped   = reg_hit(paddr, IDX_FLAG) || reg_hit(paddr, IDX_BUFFER) || reg_hit(paddr, IDX_LOC) ||
                    reg_hit(paddr, IDX_CTRL) || reg_hit(paddr, IDX_UNLOCK) || reg_hit(paddr, IDX_STATUS);

  // small variant ignores the top select bit
  assign loc_eff = LARGE_ARRAY ? loc_reg : {1'b0, loc_reg[LOC_TOP_BIT-1:0]};

  // read mux, unimplemented bits and the unlock port read zero
  always_comb
  begin
    rd_mux = DATA_ZERO;
    if (reg_hit(paddr, IDX_FLAG))
      rd_mux[FLAG_DONE_BIT] = done_reg;
    else if (reg_hit(paddr, IDX_BUFFER))
      rd_mux[7:0] = buffer_reg;
    else if (reg_hit(paddr, IDX_LOC))
      rd_mux[7:0] = loc_reg;
    else if (reg_hit(paddr, IDX_CTRL))
      rd_mux[3:0] = {abort_reg, enable_reg, wr_reg, rd_reg};  // upper nibble zero
    else if (reg_hit(paddr, IDX_STATUS))
      rd_mux[2:0] = {armed, pwrt_hold, wc_state != WC_IDLE};
    else
      rd_mux = DATA_ZERO;  // unlock port and unmapped
  end

  // no wait state: data and ready are registered in the setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_reg  <= DATA_ZERO;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end
    else if (ce)
    begin
      pready_reg  <= setup_ph;
      pslverr_reg <= setup_ph && !mapped;
      if (setup_ph)
        prdata_reg <= pwrite ? DATA_ZERO : rd_mux;
    end
  end

  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;

  // power-up hold: strap caught after release, then counted out
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pwrt_cnt_reg  <= 32'h0000_0000;
      pwrt_done_reg <= 1'b0;
    end
    else if (ce && !pwrt_done_reg)
    begin
      pwrt_cnt_reg <= pwrt_cnt_reg + 32'h0000_0001;
      if (pwrt_cnt_reg >= 32'(STRAP_SETTLE) && (!pin_sync_reg[3] || pwrt_cnt_reg >= 32'(PWRT_CYCLES - 1)))
        pwrt_done_reg <= 1'b1;
    end
  end

  assign pwrt_hold = !pwrt_done_reg;

  // unlock sequencer
  dea_unlock u_unlock (
    .pclk     (pclk),
    .presetn  (presetn),
    .ce       (ce),
    .key_wr   (wr_ev && reg_hit(paddr, IDX_UNLOCK)),
    .key_data (pwdata[7:0]),
    .other_wr (wr_ev && !reg_hit(paddr, IDX_UNLOCK)),
    .armed    (armed)
  );

  // start conditions; writes of zero to start bits do nothing
  assign start_rd = wr_ev && reg_hit(paddr, IDX_CTRL) && pwdata[CTRL_RD_BIT] && wc_state == WC_IDLE;
  assign start_wr = wr_ev && reg_hit(paddr, IDX_CTRL) && pwdata[CTRL_WR_BIT] && enable_reg && armed &&
                    !pwrt_hold && !any_rst && wc_state == WC_IDLE;

  assign phase_end = (wc_state != WC_IDLE) && (wc_cnt_reg == 32'(PHASE_CYCLES - 1));
  assign abort_ev  = any_rst && (wc_state != WC_IDLE);
  assign prog_end  = phase_end && (wc_state == WC_PROGRAM) && !abort_ev;

  // write engine: erase then program, each timed internally
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wc_state   <= WC_IDLE;
      wc_cnt_reg <= 32'h0000_0000;
    end
    else if (ce)
    begin
      wc_cnt_reg <= (phase_end || wc_state == WC_IDLE) ? 32'h0000_0000 : wc_cnt_reg + 32'h0000_0001;
      case (wc_state)
        WC_IDLE:
          if (start_wr)
            wc_state <= WC_ERASE;
        WC_ERASE:
          if (abort_ev)
            wc_state <= WC_IDLE;
          else if (phase_end)
            wc_state <= WC_PROGRAM;
        WC_PROGRAM:
          if (abort_ev || phase_end)
            wc_state <= WC_IDLE;
        default:
          wc_state <= WC_IDLE;
      endcase
    end
  end

  // target latched at start, so a cleared enable or new buffer cannot disturb it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wc_addr_reg <= 8'h00;
      wc_data_reg <= 8'h00;
    end
    else if (ce && start_wr)
    begin
      wc_addr_reg <= loc_eff;
      wc_data_reg <= buffer_reg;
    end
  end

  // array writes only at phase ends, never while held or aborting
  assign mem_we    = phase_end && !abort_ev && !pwrt_hold;
  assign mem_wdata = (wc_state == WC_ERASE) ? ERASED_BYTE : wc_data_reg;

  dea_mem u_mem (
    .pclk  (pclk),
    .ce    (ce),
    .we    (mem_we),
    .waddr (wc_addr_reg),
    .wdata (mem_wdata),
    .re    (start_rd),
    .raddr (loc_eff),
    .rdata (mem_rdata)
  );

  // start bits: set by software, cleared by hardware only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rd_reg <= 1'b0;
      wr_reg <= 1'b0;
    end
    else if (ce)
    begin
      rd_reg <= start_rd;  // one-cycle read
      if (start_wr)
        wr_reg <= 1'b1;
      else if (prog_end || abort_ev)
        wr_reg <= 1'b0;
    end
  end

  // write enable changes only by software write
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      enable_reg <= ENABLE_RESET;
    else if (ce && wr_ev && reg_hit(paddr, IDX_CTRL))
      enable_reg <= pwdata[CTRL_EN_BIT];
  end

  // abort flag: hardware set beats a software clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      abort_reg <= ABORT_RESET;
    else if (ce)
    begin
      if (abort_ev)
        abort_reg <= 1'b1;
      else if (wr_ev && reg_hit(paddr, IDX_CTRL))
        abort_reg <= pwdata[CTRL_ABORT_BIT];
    end
  end

  // done flag: set on completion, software must clear it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      done_reg <= DONE_RESET;
    else if (ce)
    begin
      if (prog_end)
        done_reg <= 1'b1;
      else if (wr_ev && reg_hit(paddr, IDX_FLAG))
        done_reg <= pwdata[FLAG_DONE_BIT];
    end
  end

  assign program_done_flag = done_reg;

  // buffer and location: untouched by aborts, buffer also loaded by reads
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      buffer_reg <= 8'h00;
      loc_reg    <= 8'h00;
    end
    else if (ce)
    begin
      if (rd_reg)
        buffer_reg <= mem_rdata;
      else if (wr_ev && reg_hit(paddr, IDX_BUFFER))
        buffer_reg <= pwdata[7:0];
      if (wr_ev && reg_hit(paddr, IDX_LOC))
        loc_reg <= pwdata[7:0];
    end
  end

  // checks
  default clocking cb @(posedge pclk iff ce);
  endclocking
  default disable iff (!presetn);

  ctrl_upper_a: assert property (setup_ph && !pwrite && reg_hit(paddr, IDX_CTRL) |=> prdata[7:4] == 4'h0)
    else $error("control upper bits not zero");
  unlock_zero_a: assert property (setup_ph && !pwrite && reg_hit(paddr, IDX_UNLOCK) |=> prdata == DATA_ZERO)
    else $error("unlock port read not zero");
  rd_load_a: assert property (rd_reg |=> !rd_reg && buffer_reg == $past(mem_rdata))
    else $error("read did not load buffer");
  buf_hold_a: assert property (!$stable(buffer_reg) |-> $past(rd_reg) || $past(wr_ev))
    else $error("buffer changed without cause");
  wr_start_a: assert property ($rose(wr_reg) |-> $past(enable_reg) && $past(armed) && $past(!pwrt_hold))
    else $error("program start without enable or unlock");
  enable_hold_a: assert property (!$stable(enable_reg) |-> $past(wr_ev) && $past(reg_hit(paddr, IDX_CTRL)))
    else $error("write enable changed by hardware");
  abort_set_a: assert property (abort_ev |=> abort_reg && !wr_reg && wc_state == WC_IDLE)
    else $error("abort not flagged");
  done_set_a: assert property (prog_end |=> done_reg && !wr_reg ##1 !wr_reg)
    else $error("completion not signalled");
  pwrt_block_a: assert property (pwrt_hold |-> !mem_we && !start_wr)
    else $error("array write during power-up hold");
  loc_keep_a: assert property (abort_ev && !wr_ev |=> $stable(loc_reg) && $stable(buffer_reg))
    else $error("select or buffer lost on abort");

endmodule : dea_top
`default_nettype wire

// ==== dea_pkg.sv ====
`default_nettype none
package dea_pkg;

  // clock and bus geometry
  localparam int          CLK_PERIOD_NS = 10;       // pclk at 100 MHz
  localparam int          PADDR_W       = 12;       // enough for index 9Eh times four
  localparam logic [31:0] DATA_ZERO     = 32'h0000_0000;

  // register indices, byte address is four times the index
  localparam logic [7:0] IDX_FLAG   = 8'h0C;  // peripheral_flag_register
  localparam logic [7:0] IDX_BUFFER = 8'h9A;  // nv_byte_buffer
  localparam logic [7:0] IDX_LOC    = 8'h9B;  // nv_location_select
  localparam logic [7:0] IDX_CTRL   = 8'h9C;  // nv_control_primary
  localparam logic [7:0] IDX_UNLOCK = 8'h9D;  // nv_unlock_port, no storage
  localparam logic [7:0] IDX_STATUS = 8'h9E;  // nv_engine_status

  // field positions
  localparam int CTRL_RD_BIT    = 0;  // read start
  localparam int CTRL_WR_BIT    = 1;  // program start
  localparam int CTRL_EN_BIT    = 2;  // program_unlock_enable
  localparam int CTRL_ABORT_BIT = 3;  // program_abort_flag
  localparam int FLAG_DONE_BIT  = 7;  // program_done_flag
  localparam int LOC_TOP_BIT    = 7;  // upper half select on the large array
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_HOLD_BIT  = 1;
  localparam int STAT_ARMED_BIT = 2;

  // values
  localparam logic [7:0] UNLOCK_KEY_FIRST  = 8'h55;
  localparam logic [7:0] UNLOCK_KEY_SECOND = 8'hAA;
  localparam logic [7:0] ERASED_BYTE       = 8'hFF;
  localparam logic       ENABLE_RESET      = 1'b0;
  localparam logic       ABORT_RESET       = 1'b0;
  localparam logic       DONE_RESET        = 1'b0;

  // timing
  localparam int UNLOCK_GAP_NS      = 200;   // longest gap between unlock steps
  localparam int UNLOCK_GAP_CYCLES  = UNLOCK_GAP_NS / CLK_PERIOD_NS;
  localparam int PWRT_MS            = 72;    // power-up write hold
  localparam int PWRT_CYCLES_DEF    = PWRT_MS * 1000000 / CLK_PERIOD_NS;
  localparam int WRITE_TIME_US      = 4000;  // erase plus program
  localparam int WRITE_CYCLES_DEF   = WRITE_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int STRAP_SETTLE       = 3;     // strap seen through the synchroniser

  typedef enum logic [1:0] {UL_IDLE, UL_GOT_FIRST, UL_GOT_SECOND} dea_unlock_t;
  typedef enum logic [1:0] {WC_IDLE, WC_ERASE, WC_PROGRAM} dea_wcycle_t;

  // true when the apb address selects the word of a register index
  function automatic logic reg_hit(input logic [PADDR_W-1:0] addr, input logic [7:0] idx);
    reg_hit = (addr == {2'b00, idx, 2'b00});
  endfunction : reg_hit

endpackage : dea_pkg
`default_nettype wire

// ==== dea_mem.sv ====
`timescale 1ns/10ps
`default_nettype none
module dea_mem
  import dea_pkg::*;
(
  // clock
  input  wire logic       pclk,
  input  wire logic       ce,
  // write port
  input  wire logic       we,
  input  wire logic [7:0] waddr,
  input  wire logic [7:0] wdata,
  // read port, data registered
  input  wire logic       re,
  input  wire logic [7:0] raddr,
  output var  logic [7:0] rdata
);

  logic [7:0] cells [256];  // the byte array, no reset like real cells

  // single write port
  always_ff @(posedge pclk)
  begin
    if (ce && we)
      cells[waddr] <= wdata;
  end

  // registered read keeps the output off the array path
  always_ff @(posedge pclk)
  begin
    if (ce && re)
      rdata <= cells[raddr];
  end

endmodule : dea_mem
`default_nettype wire

// ==== dea_unlock.sv ====
`timescale 1ns/10ps
`default_nettype none
module dea_unlock
  import dea_pkg::*;
(
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       ce,
  // register writes seen by the sequencer
  input  wire logic       key_wr,     // write to the unlock port
  input  wire logic [7:0] key_data,
  input  wire logic       other_wr,   // write to any other register
  // result
  output var  logic       armed       // next control write may start programming
);

  dea_unlock_t state_reg;
  logic [7:0]  gap_reg;  // cycles since the last step

  // sequence tracker: any stray write or slow step drops back to idle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_reg <= UL_IDLE;
    else if (ce)
    begin
      if (other_wr)
        state_reg <= UL_IDLE;  // control write consumes the unlock too
      else if (key_wr)
      begin
        if (key_data == UNLOCK_KEY_FIRST)
          state_reg <= UL_GOT_FIRST;
        else if (key_data == UNLOCK_KEY_SECOND && state_reg == UL_GOT_FIRST)
          state_reg <= UL_GOT_SECOND;
        else
          state_reg <= UL_IDLE;
      end
      else if (state_reg != UL_IDLE && gap_reg >= 8'(UNLOCK_GAP_CYCLES))
        state_reg <= UL_IDLE;  // timing broken, write suppressed
    end
  end

  // gap counter restarts at every step
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      gap_reg <= 8'h00;
    else if (ce)
    begin
      if (key_wr || other_wr || state_reg == UL_IDLE)
        gap_reg <= 8'h00;
      else if (gap_reg != 8'hFF)
        gap_reg <= gap_reg + 8'h01;
    end
  end

  assign armed = (state_reg == UL_GOT_SECOND) && (gap_reg < 8'(UNLOCK_GAP_CYCLES));

endmodule : dea_unlock
`default_nettype wire

// ==== dea_bench.sv ====
`timescale 1ns/10ps
`default_nettype none
module dea_bench
  import dea_pkg::*;
;
  // short counts keep the run brief
  localparam int PWRT_SIM  = 40;
  localparam int WRITE_SIM = 10;

  // clock, reset and apb
  logic               pclk;
  logic               presetn;
  logic               ce;
  logic               psel;
  logic               penable;
  logic               pwrite;
  logic [PADDR_W-1:0] paddr;
  logic [31:0]        pwdata;
  logic [31:0]        prdata;
  logic               pready;
  logic               pslverr;
  // reset sources and strap
  logic               external_reset_pin_n;
  logic               watchdog_timeout;
  logic               brownout_reset;
  logic               pwrt_enable;
  logic               program_done_flag;
  // bench state
  int                 n_errors;
  int                 checked;
  logic [7:0]         rnd;          // lfsr state
  logic [7:0]         model [256];  // expected array contents
  logic [7:0]         addr_list [8];
  logic [31:0]        prdata_small;      // read data of the small-array twin
  logic [31:0]        small_seen;        // twin read data, taken with the main one
  logic [7:0]         model_small [128]; // twin array, bit 7 not decoded

  dea_top #(.LARGE_ARRAY(1'b1), .PWRT_CYCLES(PWRT_SIM), .WRITE_CYCLES(WRITE_SIM)) u_dea_top (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .external_reset_pin_n(external_reset_pin_n), .watchdog_timeout(watchdog_timeout),
    .brownout_reset(brownout_reset), .pwrt_enable(pwrt_enable), .program_done_flag(program_done_flag)
  );

  // small-array twin on the same stimulus, only its read data are compared
  dea_top #(.LARGE_ARRAY(1'b0), .PWRT_CYCLES(PWRT_SIM), .WRITE_CYCLES(WRITE_SIM)) u_dea_top_small (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata_small), .pready(), .pslverr(),
    .external_reset_pin_n(external_reset_pin_n), .watchdog_timeout(watchdog_timeout),
    .brownout_reset(brownout_reset), .pwrt_enable(pwrt_enable), .program_done_flag()
  );

  // free running clock
  initial
  begin
    pclk = 1'b0;
    forever #(CLK_PERIOD_NS / 2) pclk = ~pclk;
  end

  // eight bit lfsr, taps chosen for a full period
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr

  // expected control word, upper four bits never exist
  function automatic logic [31:0] ctrl_exp(input logic wr_b, input logic en_b, input logic abort_b);
    return {28'h0000000, abort_b, en_b, wr_b, 1'b0};
  endfunction : ctrl_exp

  // one comparison, four-state exact
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // one apb transfer; an idle edge follows so psel is never assigned twice in a step
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (n >= 16)
    begin
      check("pready", {31'h00000000, pready}, 32'h00000001);
    end
    rd = prdata;
    small_seen = prdata_small;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, idx, d, r, e);
  endtask : wr

  task automatic rd_check(input string what, input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, idx, 32'h00000000, r, e);
    check(what, r, exp);
  endtask : rd_check

  // full program sequence for one byte
  task automatic prog(input logic [7:0] a, input logic [7:0] d);
    wr(IDX_LOC, {24'h000000, a});
    wr(IDX_BUFFER, {24'h000000, d});
    wr(IDX_CTRL, 32'h00000004);
    wr(IDX_UNLOCK, {24'h000000, UNLOCK_KEY_FIRST});
    wr(IDX_UNLOCK, {24'h000000, UNLOCK_KEY_SECOND});
    wr(IDX_CTRL, 32'h00000006);
  endtask : prog

  // poll until the start bit drops, bounded
  task automatic wait_done();
    logic [31:0] r;
    logic        e;
    int          n;
    n = 0;
    do
    begin
      apb(1'b0, IDX_CTRL, 32'h00000000, r, e);
      n++;
    end
    while (r[CTRL_WR_BIT] !== 1'b0 && n < 20);
    check("write finished", {31'h00000000, r[CTRL_WR_BIT]}, 32'h00000000);
  endtask : wait_done

  // verdict, reached from the main sequence or the watchdog
  task automatic results();
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
    begin
      $display("RESULT: PASS");
    end
    else
    begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : results

  // hang guard, far beyond the roughly one thousand cycles the tests need
  initial
  begin
    repeat (20000) @(posedge pclk);
    check("run time", 32'h00000001, 32'h00000000);
    results();
  end

  // main sequence
  initial
  begin
    logic [31:0] r;
    logic        e;
    logic [7:0]  a;
    logic [7:0]  d;
    n_errors = 0;
    checked = 0;
    rnd = 8'h32;
    presetn = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = 32'h00000000;
    external_reset_pin_n = 1'b1;
    watchdog_timeout = 1'b0;
    brownout_reset = 1'b0;
    pwrt_enable = 1'b1;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd_check("control at reset", IDX_CTRL, ctrl_exp(1'b0, 1'b0, 1'b0));
    // a start inside the power-up hold must be refused
    prog(8'h20, 8'h5A);
    rd_check("start in hold", IDX_CTRL, ctrl_exp(1'b0, 1'b1, 1'b0));
    repeat (PWRT_SIM) @(posedge pclk);
    wr(IDX_UNLOCK, 32'h000000FF);
    rd_check("unlock port", IDX_UNLOCK, 32'h00000000);
    apb(1'b0, 8'h40, 32'h00000000, r, e);
    check("unmapped data", r, 32'h00000000);
    check("unmapped error", {31'h00000000, e}, 32'h00000001);
    wr(IDX_CTRL, 32'h000000F0);
    rd_check("control upper bits", IDX_CTRL, ctrl_exp(1'b0, 1'b0, 1'b0));
    // keys without write enable
    wr(IDX_UNLOCK, {24'h000000, UNLOCK_KEY_FIRST});
    wr(IDX_UNLOCK, {24'h000000, UNLOCK_KEY_SECOND});
    wr(IDX_CTRL, 32'h00000002);
    rd_check("start without enable", IDX_CTRL, ctrl_exp(1'b0, 1'b0, 1'b0));
    // late key, swapped keys, interposed write
    wr(IDX_CTRL, 32'h00000004);
    for (int k = 0; k < 3; k++)
    begin
      wr(IDX_UNLOCK, (k == 1) ? 32'h000000AA : 32'h00000055);
      if (k == 0)
      begin
        repeat (25) @(posedge pclk);
      end
      if (k == 2)
      begin
        wr(IDX_LOC, 32'h00000000);
      end
      wr(IDX_UNLOCK, (k == 1) ? 32'h00000055 : 32'h000000AA);
      wr(IDX_CTRL, 32'h00000006);
      rd_check("refused start", IDX_CTRL, ctrl_exp(1'b0, 1'b1, 1'b0));
    end
    // boundary then random locations, both halves
    addr_list = '{8'h00, 8'h7F, 8'h80, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 8; i++)
    begin
      rnd = lfsr(rnd);
      a = (i < 4) ? addr_list[i] : rnd;
      addr_list[i] = a;
      rnd = lfsr(rnd);
      d = rnd;
      model[a] = d;
      model_small[a[6:0]] = d;
      prog(a, d);
      wait_done();
      rd_check("done flag", IDX_FLAG, 32'h00000080);
      check("done pin", {31'h00000000, program_done_flag}, 32'h00000001);
      wr(IDX_FLAG, 32'h00000000);
      rd_check("done flag cleared", IDX_FLAG, 32'h00000000);
    end
    for (int i = 0; i < 8; i++)
    begin
      wr(IDX_LOC, {24'h000000, addr_list[i]});
      wr(IDX_CTRL, 32'h00000005);
      rd_check("read start cleared", IDX_CTRL, ctrl_exp(1'b0, 1'b1, 1'b0));
      rd_check("array byte", IDX_BUFFER, {24'h000000, model[addr_list[i]]});
      check("small array byte", small_seen, {24'h000000, model_small[addr_list[i][6:0]]});
    end
    wr(IDX_LOC, 32'h00000000);
    rd_check("buffer held", IDX_BUFFER, {24'h000000, model[addr_list[7]]});
    // enable and start bits written to zero mid write
    prog(8'h55, 8'h3C);
    wr(IDX_CTRL, 32'h00000000);
    rd_check("write survives", IDX_CTRL, ctrl_exp(1'b1, 1'b0, 1'b0));
    wait_done();
    wr(IDX_FLAG, 32'h00000000);
    wr(IDX_LOC, 32'h00000055);
    wr(IDX_CTRL, 32'h00000001);
    rd_check("finished byte", IDX_BUFFER, 32'h0000003C);
    // a low clock enable freezes the write timer, so the write is still busy after it
    prog(8'h66, 8'h99);
    ce <= 1'b0;
    repeat (30) @(posedge pclk);
    ce <= 1'b1;
    rd_check("frozen write", IDX_CTRL, ctrl_exp(1'b1, 1'b1, 1'b0));
    wait_done();
    wr(IDX_FLAG, 32'h00000000);
    // each reset source cuts a write short
    for (int k = 0; k < 3; k++)
    begin
      prog(8'h10 + k[7:0], 8'hA0 + k[7:0]);
      external_reset_pin_n <= (k != 0);
      watchdog_timeout <= (k == 1);
      brownout_reset <= (k == 2);
      repeat (4) @(posedge pclk);
      external_reset_pin_n <= 1'b1;
      watchdog_timeout <= 1'b0;
      brownout_reset <= 1'b0;
      repeat (6) @(posedge pclk);
      rd_check("abort flag", IDX_CTRL, ctrl_exp(1'b0, 1'b1, 1'b1));
      rd_check("location kept", IDX_LOC, {24'h000000, 8'h10 + k[7:0]});
      rd_check("buffer kept", IDX_BUFFER, {24'h000000, 8'hA0 + k[7:0]});
      wr(IDX_CTRL, 32'h00000004);
      rd_check("abort cleared", IDX_CTRL, ctrl_exp(1'b0, 1'b1, 1'b0));
    end
    results();
  end

endmodule : dea_bench
`default_nettype wire
